// file: dv/rng_consumer_model.sv
`timescale 1ns/100ps
module rng_consumer_model
	import rng_gate_pkg::*;
(
	input wire logic mclk_i,
	input wire logic reset_i,
	input wire logic word_valid_i,
	input wire logic [rng_gate_pkg::WORD_W-1:0] word_i,
	output logic word_ready_o,
	output logic took_o,
	output logic [rng_gate_pkg::WORD_W-1:0] got_o
);
	import rng_gate_pkg::*;
	logic [1:0] pace_r;
	// Stall one cycle in four so words must stand
	always_ff @(posedge mclk_i) begin
		pace_r <= reset_i ? 2'h0 : pace_r + 2'h1;
	end
	assign word_ready_o = (pace_r != 2'h3);
	always_ff @(posedge mclk_i) begin
		took_o <= !reset_i && word_valid_i && word_ready_o;
		got_o <= word_i;
	end
endmodule

// file: dv/rng_health_gate_asserts.sv
`timescale 1ns/100ps
module rng_health_gate_asserts
	import rng_gate_pkg::*;
(
	input wire logic mclk_i,
	input wire logic reset_i,
	input wire logic word_ready_i,
	input wire logic [rng_gate_pkg::WORD_W-1:0] word_o,
	input wire logic word_valid_o,
	input wire logic total_fail_o,
	input wire logic defect_o,
	input wire logic startup_done_o
);
	import rng_gate_pkg::*;
	// ==========
	// Output gating
	default clocking @(posedge mclk_i); endclocking
	default disable iff (reset_i);
	a_valid_needs_start:
	assert property (word_valid_o |-> startup_done_o) else $error("valid before startup");
	a_total_blocks:
	assert property (total_fail_o |-> !word_valid_o) else $error("valid after total fail");
	a_defect_blocks:
	assert property (defect_o |-> !word_valid_o) else $error("valid under defect");
	a_total_sticky:
	assert property (total_fail_o |=> total_fail_o) else $error("total fail cleared");
	a_defect_sticky:
	assert property (defect_o |=> defect_o) else $error("defect cleared");
	a_idle_zero:
	assert property (!word_valid_o |-> word_o == '0) else $error("word not zero");
	a_take_clears:
	assert property (word_valid_o && word_ready_i |=> !word_valid_o || word_o != $past(word_o))
		else $error("taken word stayed");
	a_unread_stays:
	assert property (word_valid_o && !word_ready_i |=> word_valid_o || total_fail_o || defect_o)
		else $error("unread word lost");
	cover property (word_valid_o && word_ready_i);
	cover property (total_fail_o);
	cover property (defect_o);
endmodule
bind rng_health_gate rng_health_gate_asserts rng_health_gate_asserts_inst (.mclk_i(mclk_i),
	.reset_i(reset_i), .word_ready_i(word_ready_i), .word_o(word_o), .word_valid_o(word_valid_o),
	.total_fail_o(total_fail_o), .defect_o(defect_o), .startup_done_o(startup_done_o));

// file: dv/rng_health_gate_test.sv
`timescale 1ns/100ps
module rng_health_gate_test;
	import rng_gate_pkg::*;
	logic mclk_i = 0, reset_i = 1, raw_bit_i = 0, raw_valid_i = 0, word_ready_i;
	logic word_valid_o, total_fail_o, defect_o, startup_done_o, took;
	logic [WORD_W-1:0] word_o, got, w;
	logic [31:0] rs = 32'h0000_0048;
	logic [WORD_W-1:0] exp_q[$];
	int err_count = 0, tests_run = 0;
	always #2 mclk_i = ~mclk_i;
	rng_health_gate #(.STUCK_N(16), .WIN_N(32), .LO_N(8), .HI_N(24)) rng_health_gate_inst (.mclk_i(mclk_i),
		.reset_i(reset_i), .raw_bit_i(raw_bit_i), .raw_valid_i(raw_valid_i), .word_ready_i(word_ready_i),
		.word_o(word_o), .word_valid_o(word_valid_o), .total_fail_o(total_fail_o), .defect_o(defect_o),
		.startup_done_o(startup_done_o));
	rng_consumer_model rng_consumer_model_inst (.mclk_i(mclk_i), .reset_i(reset_i),
		.word_valid_i(word_valid_o), .word_i(word_o), .word_ready_o(word_ready_i), .took_o(took), .got_o(got));
	// ==========
	// Helpers
	function logic [31:0] xs();
		rs ^= rs << 13;
		rs ^= rs >> 17;
		rs ^= rs << 5;
		return rs;
	endfunction
	task cmp(input logic [WORD_W-1:0] g, input logic [WORD_W-1:0] e);
		tests_run++;
		if (g !== e) begin
			err_count++;
			$display("BAD t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask
	// Strobe held 3 cycles high and 4 low, bit stable throughout
	task send(input logic [31:0] v, input bit keep);
		if (keep) exp_q.push_back(v);
		for (int i = 31; i >= 0; i--) begin
			@(negedge mclk_i);
			raw_bit_i = v[i];
			raw_valid_i = 1;
			repeat (3) @(negedge mclk_i);
			raw_valid_i = 0;
			repeat (3) @(negedge mclk_i);
		end
		repeat (20) @(negedge mclk_i);
	endtask
	task boot();
		reset_i = 1;
		repeat (3) @(negedge mclk_i);
		reset_i = 0;
		cmp(startup_done_o, 0);
		send(xs(), 0);
		send(xs(), 0);
		cmp(startup_done_o, 1);
	endtask
	task tally_and_finish();
		$display("counts: run=%0d bad=%0d", tests_run, err_count);
		if (err_count == 0 && tests_run > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask
	// Every taken word must be the next one the model expects
	always @(negedge mclk_i) begin
		if (took === 1'b1) cmp(got, exp_q.size() ? exp_q.pop_front() : 'x);
	end
	// ==========
	// Scenarios
	initial begin
		boot();
		repeat (4) send(xs(), 1);
		cmp(exp_q.size(), 0);
		$display("test done: stream");
		w = xs();
		send(w, 1);
		send(w, 0);
		cmp(defect_o, 1);
		cmp(exp_q.size(), 0);
		$display("test done: repeat");
		boot();
		send(32'h0000_0000, 0);
		cmp(total_fail_o, 1);
		send(xs(), 0);
		cmp(word_valid_o, 0);
		$display("test done: total");
		tally_and_finish();
	end
	// Hang guard, several times the expected run
	initial begin
		#100000;
		err_count++;
		tally_and_finish();
	end
endmodule

// file: rtl/rng_gate_pkg.sv
package rng_gate_pkg;
	// ==========================================================
	// Word and test geometry
	localparam int WORD_W = 32;
	// Raw bits of one identical run that count as total failure
	localparam int STUCK_LIMIT = 32;
	// Online test window and bounds on ones per window
	localparam int WIN_BITS = 256;
	localparam int ONES_MIN = 96;
	localparam int ONES_MAX = 160;
	// Power-up test: windows that must pass before output opens
	localparam int POWERUP_WINDOWS = 2;
	localparam int CNT_W = 9;

	// Health states, one-hot
	typedef enum logic [3:0] {
		ST_POWERUP = 4'b0001,
		ST_RUN = 4'b0010,
		ST_DEFECT = 4'b0100,
		ST_TOTAL = 4'b1000
	} health_t;
endpackage

// file: rtl/rng_health_gate.sv
`timescale 1ns/100ps
module rng_health_gate
	import rng_gate_pkg::*;
#(
	parameter int STUCK_N = STUCK_LIMIT,
	parameter int WIN_N = WIN_BITS,
	parameter int LO_N = ONES_MIN,
	parameter int HI_N = ONES_MAX
) (
	input wire logic mclk_i,
	input wire logic reset_i,
	input wire logic raw_bit_i,
	input wire logic raw_valid_i,
	input wire logic word_ready_i,
	output logic [rng_gate_pkg::WORD_W-1:0] word_o,
	output logic word_valid_o,
	output logic total_fail_o,
	output logic defect_o,
	output logic startup_done_o
);
	import rng_gate_pkg::*;

	// ==========================================================
	// Raw input synchroniser (entropy source is asynchronous)
	logic [2:0] bit_sync_r;
	logic [2:0] vld_sync_r;
	logic raw_bit;
	logic raw_stb;
	logic vld_prev_r;
	always_ff @(posedge mclk_i) begin
		if (reset_i) begin
			bit_sync_r <= 3'b000;
			vld_sync_r <= 3'b000;
			vld_prev_r <= 1'b0;
		end else begin
			bit_sync_r <= {bit_sync_r[1:0], raw_bit_i};
			vld_sync_r <= {vld_sync_r[1:0], raw_valid_i};
			vld_prev_r <= vld_sync_r[2];
		end
	end
	// Change is believed once stages two and three agree
	logic vld_stable;
	assign vld_stable = (vld_sync_r[1] == vld_sync_r[2]) ? vld_sync_r[2] : vld_prev_r;
	assign raw_stb = vld_stable & ~vld_prev_r;
	assign raw_bit = bit_sync_r[2];

	// ==========================================================
	// Total failure: run of identical bits
	logic last_bit_r;
	logic [CNT_W-1:0] run_r;
	logic total_r;
	always_ff @(posedge mclk_i) begin
		if (reset_i) begin
			last_bit_r <= 1'b0;
			run_r <= '0;
			total_r <= 1'b0;
		end else if (raw_stb) begin
			last_bit_r <= raw_bit;
			if (raw_bit == last_bit_r && run_r != '0) begin
				run_r <= run_r + 1'b1;
				if (run_r + 1'b1 >= CNT_W'(STUCK_N))
					total_r <= 1'b1;
			end else begin
				run_r <= CNT_W'(1);
			end
		end
	end

	// ==========================================================
	// Online test: ones count per window, always running
	logic [CNT_W-1:0] win_cnt_r;
	logic [CNT_W-1:0] ones_r;
	logic win_fail_r;
	logic win_pass_stb_r;
	logic [1:0] pass_cnt_r;
	logic [CNT_W-1:0] ones_now;
	assign ones_now = ones_r + CNT_W'(raw_bit);
	// evaluated every window with no trigger
	always_ff @(posedge mclk_i) begin
		if (reset_i) begin
			win_cnt_r <= '0;
			ones_r <= '0;
			win_fail_r <= 1'b0;
			win_pass_stb_r <= 1'b0;
		end else begin
			win_pass_stb_r <= 1'b0;
			if (raw_stb) begin
				if (win_cnt_r == CNT_W'(WIN_N - 1)) begin
					win_cnt_r <= '0;
					ones_r <= '0;
					if (ones_now < CNT_W'(LO_N) || ones_now > CNT_W'(HI_N))
						win_fail_r <= 1'b1;
					else
						win_pass_stb_r <= 1'b1;
				end else begin
					win_cnt_r <= win_cnt_r + 1'b1;
					ones_r <= ones_now;
				end
			end
		end
	end

	// ==========================================================
	// Word assembly and repeat test
	logic [WORD_W-1:0] shift_r;
	logic [5:0] nbits_r;
	logic [WORD_W-1:0] prev_word_r;
	logic have_prev_r;
	logic repeat_fail_r;
	logic word_stb_r;
	logic [WORD_W-1:0] new_word_r;
	logic [WORD_W-1:0] shift_nxt;
	assign shift_nxt = {shift_r[WORD_W-2:0], raw_bit};
	always_ff @(posedge mclk_i) begin
		if (reset_i) begin
			shift_r <= '0;
			nbits_r <= '0;
			word_stb_r <= 1'b0;
			new_word_r <= '0;
		end else begin
			word_stb_r <= 1'b0;
			if (raw_stb) begin
				shift_r <= shift_nxt;
				if (nbits_r == 6'(WORD_W - 1)) begin
					nbits_r <= '0;
					new_word_r <= shift_nxt;
					word_stb_r <= 1'b1;
				end else begin
					nbits_r <= nbits_r + 1'b1;
				end
			end
		end
	end
	// repeated word fails the continuous test
	always_ff @(posedge mclk_i) begin
		if (reset_i) begin
			prev_word_r <= '0;
			have_prev_r <= 1'b0;
			repeat_fail_r <= 1'b0;
		end else if (word_stb_r) begin
			prev_word_r <= new_word_r;
			have_prev_r <= 1'b1;
			if (have_prev_r && new_word_r == prev_word_r)
				repeat_fail_r <= 1'b1;
		end
	end

	// ==========================================================
	// Health state
	health_t state_r;
	always_ff @(posedge mclk_i) begin
		if (reset_i) begin
			state_r <= ST_POWERUP;
			pass_cnt_r <= '0;
		end else begin
			unique case (state_r)
				ST_POWERUP: begin
					if (total_r)
						state_r <= ST_TOTAL;
					else if (win_fail_r || repeat_fail_r)
						state_r <= ST_DEFECT;
					// open only after power-up windows pass
					else if (win_pass_stb_r) begin
						if (pass_cnt_r == 2'(POWERUP_WINDOWS - 1))
							state_r <= ST_RUN;
						pass_cnt_r <= pass_cnt_r + 1'b1;
					end
				end
				ST_RUN: begin
					if (total_r)
						state_r <= ST_TOTAL;
					else if (win_fail_r || repeat_fail_r)
						state_r <= ST_DEFECT;
				end
				// Defect is left only for ST_TOTAL or by reset; a weak source is not trusted again
				ST_DEFECT: begin
					if (total_r)
						state_r <= ST_TOTAL;
				end
				ST_TOTAL: state_r <= ST_TOTAL;
				default: state_r <= ST_TOTAL;
			endcase
		end
	end

	// ==========================================================
	// Output word holding register
	// A word finished in the same cycle as a failure flag is never loaded,
	// since its bits may postdate the failure.
	logic healthy;
	logic [WORD_W-1:0] out_word_r;
	logic out_full_r;
	assign healthy = (state_r == ST_RUN) && !total_r && !win_fail_r && !repeat_fail_r;
	always_ff @(posedge mclk_i) begin
		if (reset_i) begin
			out_word_r <= '0;
			out_full_r <= 1'b0;
		end else if (!healthy) begin
			out_full_r <= 1'b0;
			out_word_r <= '0;
		end else if (word_stb_r && !(have_prev_r && new_word_r == prev_word_r)) begin
			out_word_r <= new_word_r;
			out_full_r <= 1'b1;
		end else if (word_ready_i) begin
			// Taken word is wiped so a stale value never sits on the bus
			out_full_r <= 1'b0;
			out_word_r <= '0;
		end
	end

	assign word_valid_o = out_full_r && healthy;
	assign word_o = out_word_r;
	assign total_fail_o = total_r;
	assign defect_o = (state_r == ST_DEFECT) || win_fail_r || repeat_fail_r;
	assign startup_done_o = (state_r == ST_RUN);
endmodule
